/* File: ciu_core_irq.sv */
// ciu_core_irq: flags, enables, request gating, entry timing and context shadow
// assumes the core sits on ref_clk_i and follows q_phase_o; ext pin is asynchronous
//
// How it works
// - vector starts 9-12 reference clocks after synchronous, 11-15 after asynchronous events.
// - entry latency ignores the length of the running instruction.
// - external flag may set in q4..q1; request sampled once per cycle at q1.
// - wake with global enable branches to vector, otherwise continues in line.
// - the instruction after sleep always runs before the branch.
// - external pin gives an edge interrupt enabled by control bit 4.
// - edge select set means rising edge, clear means falling edge.
// - valid edge sets external flag; with both enables it redirects to vector.
// - entry pushes pc and saves w, status-less-flags, bank, file select, latch.
// - return reloads the shadow copies, including software edits to them.
// - shadow copies are readable and writable in bank 31.
// - every flag sets on its event whatever the enables are.
// - global enable bit 7 passes enabled interrupts, blocks all when clear.
// - peripheral group enable bit 6 gates all peripheral register sources.
// - timer0 overflow flag bit 2, its enable bit 5.
// - read-only pin-change flag bit 0 follows pending changes, enable bit 3.
// - first enable register: gate bit 7, adc bit 6, timer1 overflow bit 0.
// - first pending register mirrors those positions, 1 pending, software writable.
// - second enable and pending registers hold the lcd bit at 2.
// - unimplemented enable and pending bits read as zero.
// - taking flushes prefetch, clears global enable, pushes pc, loads vector.
// - return pops pc, restores context and sets global enable again.
// - every reset leaves all interrupts disabled.
`timescale 1ns/10ps
module ciu_core_irq (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// register port
	input wire logic [ciu_pkg::CIU_AW-1:0] reg_addr_i,
	input wire logic [ciu_pkg::CIU_DW-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [ciu_pkg::CIU_DW-1:0] reg_rdata_o,
	// interrupt sources
	input wire logic ext_pin_i,
	input wire logic pin_change_i,
	input wire ciu_pkg::ciu_events_t events_i,
	// core side
	input wire ciu_pkg::ciu_ctx_t ctx_live_i,
	input wire logic return_from_irq_i,
	input wire logic sleep_i,
	output logic [1:0] q_phase_o,
	output logic irq_take_o,
	output logic vector_go_o,
	output logic [14:0] vector_addr_o,
	output logic restore_o,
	output ciu_pkg::ciu_ctx_t ctx_restore_o,
	output logic wake_o,
	output logic global_irq_enable_o
);
	import ciu_pkg::*;

	typedef enum {CIU_RUN, CIU_ENTRY} ciu_state_t;

	function automatic logic ciu_hit(input logic [11:0] a, input logic [11:0] b);
		ciu_hit = (a == b);
	endfunction

	function automatic logic ciu_sh_hit(input logic [11:0] a, input logic [6:0] off);
		ciu_sh_hit = (a == {CIU_SHADOW_BANK, off});
	endfunction

	ciu_state_t state_reg;
	logic [1:0] qph_reg;
	logic [1:0] tcy_cnt_reg;
	logic [7:0] ctrl_reg;
	logic [7:0] en_a_reg;
	logic [7:0] en_b_reg;
	logic [7:0] pend_a_reg;
	logic [7:0] pend_b_reg;
	logic [7:0] t0opt_reg;
	ciu_ctx_t shadow_reg;
	logic ext_s1_reg;
	logic ext_s2_reg;
	logic ext_s3_reg;
	logic sleep_d_reg;
	logic hold_reg;
	logic [1:0] hold_cnt_reg;
	logic take_reg;
	logic go_reg;
	logic restore_reg;
	logic [7:0] rdata_reg;
	logic q1;
	logic ext_edge;
	logic periph_any;
	logic core_any;
	logic any_enabled;
	logic irq_req;
	logic take_now;
	logic wr_ctrl;
	logic wr_pa;
	logic wr_pb;
	logic wake_fall;

	// instruction cycle phases
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			qph_reg <= CIU_Q1;
		end else begin
			qph_reg <= qph_reg + 2'h1;
		end
	end
	assign q1 = (qph_reg == CIU_Q1);
	assign q_phase_o = qph_reg;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ext_s1_reg <= 1'b0;
			ext_s2_reg <= 1'b0;
			ext_s3_reg <= 1'b0;
		end else begin
			ext_s1_reg <= ext_pin_i;
			ext_s2_reg <= ext_s1_reg;
			ext_s3_reg <= ext_s2_reg;
		end
	end
	assign ext_edge = t0opt_reg[CIU_B_EDGE] ? (ext_s2_reg & ~ext_s3_reg) : (~ext_s2_reg & ext_s3_reg);

	assign wr_ctrl = reg_wr_i && ciu_hit(reg_addr_i, CIU_A_CORE_CTRL);
	assign wr_pa = reg_wr_i && ciu_hit(reg_addr_i, CIU_A_PEND_A);
	assign wr_pb = reg_wr_i && ciu_hit(reg_addr_i, CIU_A_PEND_B);

	assign periph_any = |(pend_a_reg & en_a_reg & CIU_MASK_A) | |(pend_b_reg & en_b_reg & CIU_MASK_B);
	assign core_any = (ctrl_reg[CIU_B_T0F] & ctrl_reg[CIU_B_T0E]) | (ctrl_reg[CIU_B_EXF] & ctrl_reg[CIU_B_EXE])
		| (ctrl_reg[CIU_B_PCF] & ctrl_reg[CIU_B_PCE]);
	assign any_enabled = core_any | (periph_any & ctrl_reg[CIU_B_PGE]);
	assign irq_req = any_enabled & ctrl_reg[CIU_B_GLB];
	assign take_now = q1 && irq_req && (state_reg == CIU_RUN) && !hold_reg && !wake_fall && !sleep_i;

	// core flags set regardless of enables, set wins over write
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ctrl_reg <= CIU_RST_REG;
		end else begin
			if (wr_ctrl) begin
				ctrl_reg[7:1] <= reg_wdata_i[7:1];
			end
			if (take_now) begin
				ctrl_reg[CIU_B_GLB] <= 1'b0;
			end else if (return_from_irq_i) begin
				ctrl_reg[CIU_B_GLB] <= 1'b1;
			end
			if (events_i.timer0_ovf) begin
				ctrl_reg[CIU_B_T0F] <= 1'b1;
			end
			if (ext_edge) begin
				ctrl_reg[CIU_B_EXF] <= 1'b1;
			end
			ctrl_reg[CIU_B_PCF] <= pin_change_i;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			en_a_reg <= CIU_RST_REG;
			en_b_reg <= CIU_RST_REG;
			t0opt_reg <= CIU_RST_T0_OPT;
		end else begin
			if (reg_wr_i && ciu_hit(reg_addr_i, CIU_A_EN_A)) begin
				en_a_reg <= reg_wdata_i & CIU_MASK_A;
			end
			if (reg_wr_i && ciu_hit(reg_addr_i, CIU_A_EN_B)) begin
				en_b_reg <= reg_wdata_i & CIU_MASK_B;
			end
			if (reg_wr_i && ciu_hit(reg_addr_i, CIU_A_T0_OPT)) begin
				t0opt_reg <= reg_wdata_i;
			end
		end
	end

	// pending registers, events win over software
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			pend_a_reg <= CIU_RST_REG;
			pend_b_reg <= CIU_RST_REG;
		end else begin
			pend_a_reg <= (wr_pa ? (reg_wdata_i & CIU_MASK_A) : pend_a_reg)
				| ({7'h00, events_i.timer1_ovf} << CIU_B_T1O)
				| ({7'h00, events_i.timer1_gate} << CIU_B_T1G)
				| ({7'h00, events_i.adc_done} << CIU_B_ADC);
			pend_b_reg <= (wr_pb ? (reg_wdata_i & CIU_MASK_B) : pend_b_reg)
				| ({7'h00, events_i.lcd_event} << CIU_B_LCD);
		end
	end

	// hold one instruction cycle after wake
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			sleep_d_reg <= 1'b0;
			hold_reg <= 1'b0;
			hold_cnt_reg <= 2'h0;
		end else begin
			sleep_d_reg <= sleep_i;
			if (sleep_d_reg && !sleep_i) begin
				hold_reg <= 1'b1;
				hold_cnt_reg <= 2'(CIU_Q_PER_TCY - 1);
			end else if (hold_reg) begin
				hold_cnt_reg <= hold_cnt_reg - 2'h1;
				if (hold_cnt_reg == 2'h0) begin
					hold_reg <= 1'b0;
				end
			end
		end
	end
	assign wake_fall = sleep_d_reg & ~sleep_i;
	assign wake_o = sleep_i & any_enabled;

	// entry sequence counts fixed cycles only
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			state_reg <= CIU_RUN;
			tcy_cnt_reg <= 2'h0;
			take_reg <= 1'b0;
			go_reg <= 1'b0;
		end else begin
			take_reg <= take_now;
			go_reg <= 1'b0;
			case (state_reg)
				CIU_RUN: begin
					if (take_now) begin
						state_reg <= CIU_ENTRY;
						tcy_cnt_reg <= 2'h0;
					end
				end
				CIU_ENTRY: begin
					if (q1) begin
						if (tcy_cnt_reg == CIU_ENTRY_TCY - 2'h1) begin
							go_reg <= 1'b1;
							state_reg <= CIU_RUN;
						end
						tcy_cnt_reg <= tcy_cnt_reg + 2'h1;
					end
				end
				default: begin
					state_reg <= CIU_RUN;
				end
			endcase
		end
	end
	assign irq_take_o = take_reg;
	assign vector_go_o = go_reg;
	assign vector_addr_o = CIU_VECTOR;
	assign global_irq_enable_o = ctrl_reg[CIU_B_GLB];

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			shadow_reg <= '0;
		end else if (take_now) begin
			shadow_reg <= ctx_live_i;
			shadow_reg.status <= ctx_live_i.status & CIU_STATUS_KEEP;
		end else if (reg_wr_i && reg_addr_i[11:7] == CIU_SHADOW_BANK) begin
			case (reg_addr_i[6:0])
				CIU_SH_STATUS: shadow_reg.status <= reg_wdata_i & CIU_STATUS_KEEP;
				CIU_SH_W: shadow_reg.w <= reg_wdata_i;
				CIU_SH_BANK: shadow_reg.bank_sel <= reg_wdata_i[4:0];
				CIU_SH_PCLATCH: shadow_reg.pclatch <= reg_wdata_i[6:0];
				CIU_SH_PTR0L: shadow_reg.ptr0[7:0] <= reg_wdata_i;
				CIU_SH_PTR0H: shadow_reg.ptr0[15:8] <= reg_wdata_i;
				CIU_SH_PTR1L: shadow_reg.ptr1[7:0] <= reg_wdata_i;
				CIU_SH_PTR1H: shadow_reg.ptr1[15:8] <= reg_wdata_i;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			restore_reg <= 1'b0;
		end else begin
			restore_reg <= return_from_irq_i;
		end
	end
	assign restore_o = restore_reg;
	assign ctx_restore_o = shadow_reg;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			rdata_reg <= 8'h00;
		end else if (reg_rd_i) begin
			if (ciu_hit(reg_addr_i, CIU_A_CORE_CTRL)) rdata_reg <= ctrl_reg;
			else if (ciu_hit(reg_addr_i, CIU_A_EN_A)) rdata_reg <= en_a_reg & CIU_MASK_A;
			else if (ciu_hit(reg_addr_i, CIU_A_EN_B)) rdata_reg <= en_b_reg & CIU_MASK_B;
			else if (ciu_hit(reg_addr_i, CIU_A_PEND_A)) rdata_reg <= pend_a_reg & CIU_MASK_A;
			else if (ciu_hit(reg_addr_i, CIU_A_PEND_B)) rdata_reg <= pend_b_reg & CIU_MASK_B;
			else if (ciu_hit(reg_addr_i, CIU_A_T0_OPT)) rdata_reg <= t0opt_reg;
			else if (ciu_sh_hit(reg_addr_i, CIU_SH_STATUS)) rdata_reg <= shadow_reg.status;
			else if (ciu_sh_hit(reg_addr_i, CIU_SH_W)) rdata_reg <= shadow_reg.w;
			else if (ciu_sh_hit(reg_addr_i, CIU_SH_BANK)) rdata_reg <= {3'h0, shadow_reg.bank_sel};
			else if (ciu_sh_hit(reg_addr_i, CIU_SH_PCLATCH)) rdata_reg <= {1'h0, shadow_reg.pclatch};
			else if (ciu_sh_hit(reg_addr_i, CIU_SH_PTR0L)) rdata_reg <= shadow_reg.ptr0[7:0];
			else if (ciu_sh_hit(reg_addr_i, CIU_SH_PTR0H)) rdata_reg <= shadow_reg.ptr0[15:8];
			else if (ciu_sh_hit(reg_addr_i, CIU_SH_PTR1L)) rdata_reg <= shadow_reg.ptr1[7:0];
			else if (ciu_sh_hit(reg_addr_i, CIU_SH_PTR1H)) rdata_reg <= shadow_reg.ptr1[15:8];
			else rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= 8'h00;
		end
	end
	assign reg_rdata_o = rdata_reg;

	// checks
	AST_VECTOR_AFTER_TAKE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		irq_take_o |-> ##8 vector_go_o)
		else $error("vector not started two cycles after entry");
	AST_NO_EARLY_VECTOR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		irq_take_o |-> !vector_go_o [*8])
		else $error("vector started early");
	AST_TAKE_AT_Q1: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		irq_take_o |-> $past(q1))
		else $error("entry not sampled at q1");
	AST_NO_TAKE_IN_HOLD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$fell(sleep_i) |-> !irq_take_o [*4])
		else $error("branch before instruction after sleep");
	AST_EDGE_SETS_FLAG: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		ext_edge |=> ctrl_reg[CIU_B_EXF])
		else $error("edge did not set external flag");
	AST_RISING_SEL: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		($rose(ext_s2_reg) && t0opt_reg[CIU_B_EDGE] && !$past(wr_ctrl)) |=> ctrl_reg[CIU_B_EXF])
		else $error("rising edge missed");
	AST_GLB_CLEAR_ON_TAKE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		irq_take_o |-> !global_irq_enable_o)
		else $error("global enable still set after entry");
	AST_GLB_SET_ON_RET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(return_from_irq_i && !take_now) |=> global_irq_enable_o && restore_o)
		else $error("return did not re-enable");
	AST_NO_REQ_WITHOUT_GLB: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!$past(ctrl_reg[CIU_B_GLB]) |-> !irq_take_o)
		else $error("entry with global enable clear");
	AST_SAVE_CTX: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		irq_take_o |-> shadow_reg.w == $past(ctx_live_i.w) && shadow_reg.status[4:3] == 2'h0)
		else $error("context not saved");
	AST_UNUSED_ZERO: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$past(reg_rd_i && ciu_hit(reg_addr_i, CIU_A_PEND_A)) |-> reg_rdata_o[5:1] == 5'h00)
		else $error("unimplemented bits read nonzero");
	AST_PERIPH_SET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		events_i.adc_done |=> pend_a_reg[CIU_B_ADC])
		else $error("adc flag not set");
	AST_WAKE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(sleep_i && core_any) |-> wake_o)
		else $error("no wake");
	COV_ENTRY: cover property (@(posedge ref_clk_i) disable iff (rst_i) irq_take_o ##8 vector_go_o);
	COV_EXT_IRQ: cover property (@(posedge ref_clk_i) disable iff (rst_i) ext_edge ##[1:8] irq_take_o);
	COV_RETURN: cover property (@(posedge ref_clk_i) disable iff (rst_i) restore_o);
	COV_WAKE: cover property (@(posedge ref_clk_i) disable iff (rst_i) wake_o ##1 $fell(sleep_i));
endmodule

/* File: ciu_pkg.sv */
// ciu_pkg: constants and carrier types of the core interrupt unit
// assumes one instruction cycle of four reference clocks (q1..q4)
package ciu_pkg;
	localparam int CIU_AW = 12;
	localparam int CIU_DW = 8;
	// register addresses: bank in [11:7], offset in [6:0]
	localparam logic [11:0] CIU_A_CORE_CTRL = 12'h010;
	localparam logic [11:0] CIU_A_EN_A = 12'h011;
	localparam logic [11:0] CIU_A_EN_B = 12'h012;
	localparam logic [11:0] CIU_A_PEND_A = 12'h013;
	localparam logic [11:0] CIU_A_PEND_B = 12'h014;
	localparam logic [11:0] CIU_A_T0_OPT = 12'h015;
	localparam logic [4:0] CIU_SHADOW_BANK = 5'h1f;
	localparam logic [6:0] CIU_SH_STATUS = 7'h64;
	localparam logic [6:0] CIU_SH_W = 7'h65;
	localparam logic [6:0] CIU_SH_BANK = 7'h66;
	localparam logic [6:0] CIU_SH_PCLATCH = 7'h67;
	localparam logic [6:0] CIU_SH_PTR0L = 7'h68;
	localparam logic [6:0] CIU_SH_PTR0H = 7'h69;
	localparam logic [6:0] CIU_SH_PTR1L = 7'h6a;
	localparam logic [6:0] CIU_SH_PTR1H = 7'h6b;
	// core control bits
	localparam int CIU_B_GLB = 7;
	localparam int CIU_B_PGE = 6;
	localparam int CIU_B_T0E = 5;
	localparam int CIU_B_EXE = 4;
	localparam int CIU_B_PCE = 3;
	localparam int CIU_B_T0F = 2;
	localparam int CIU_B_EXF = 1;
	localparam int CIU_B_PCF = 0;
	// peripheral bits
	localparam int CIU_B_T1G = 7;
	localparam int CIU_B_ADC = 6;
	localparam int CIU_B_T1O = 0;
	localparam int CIU_B_LCD = 2;
	localparam int CIU_B_EDGE = 6;
	localparam logic [7:0] CIU_MASK_A = 8'hc1;
	localparam logic [7:0] CIU_MASK_B = 8'h04;
	localparam logic [7:0] CIU_STATUS_KEEP = 8'he7;
	// reset values
	localparam logic [7:0] CIU_RST_REG = 8'h00;
	localparam logic [7:0] CIU_RST_T0_OPT = 8'hff;
	// timing
	localparam int CIU_Q_PER_TCY = 4;
	localparam logic [1:0] CIU_Q1 = 2'h0;
	localparam logic [1:0] CIU_ENTRY_TCY = 2'h2;
	localparam logic [14:0] CIU_VECTOR = 15'h0004;

	typedef struct packed {
		logic timer0_ovf;
		logic timer1_ovf;
		logic timer1_gate;
		logic adc_done;
		logic lcd_event;
	} ciu_events_t;

	typedef struct packed {
		logic [7:0] status;
		logic [7:0] w;
		logic [4:0] bank_sel;
		logic [6:0] pclatch;
		logic [15:0] ptr0;
		logic [15:0] ptr1;
	} ciu_ctx_t;
endpackage

/* File: ciu_core_model.sv */
// ciu_core_model: behavioural core sequencer facing the interrupt unit
// assumes the bench loads the live context and asks for returns
`timescale 1ns/10ps
module ciu_core_model
	import ciu_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// bench control
	input wire logic ctx_set_i,
	input wire ciu_pkg::ciu_ctx_t ctx_val_i,
	input wire logic ret_req_i,
	// interrupt unit side
	input wire logic restore_i,
	input wire ciu_pkg::ciu_ctx_t ctx_restore_i,
	output ciu_pkg::ciu_ctx_t ctx_live_o,
	output logic return_from_irq_o
);
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ctx_live_o <= '0;
		end else if (restore_i) begin
			ctx_live_o <= ctx_restore_i;
		end else if (ctx_set_i) begin
			ctx_live_o <= ctx_val_i;
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			return_from_irq_o <= 1'b0;
		end else begin
			return_from_irq_o <= ret_req_i;
		end
	end
endmodule

/* File: testbench.sv */
// testbench: register, event, entry, return, pin and sleep scenarios
// assumes ciu_core_irq and ciu_core_model, one 40 MHz clock
`timescale 1ns/10ps
module testbench;
	import ciu_pkg::*;
	logic ref_clk_i, rst_i, reg_wr, reg_rd, ext_pin, pin_chg, sleep, ret_req, ctx_set;
	logic [11:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, rv;
	ciu_events_t events;
	ciu_ctx_t ctx_live, ctx_restore, ctx_val;
	logic [1:0] q_phase;
	logic irq_take, vector_go, restore, wake, glb_en, ret_pulse;
	logic [14:0] vec_addr;
	int err_count, comparisons, cycles, n, k;

	ciu_core_irq u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
		.reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .ext_pin_i(ext_pin),
		.pin_change_i(pin_chg), .events_i(events), .ctx_live_i(ctx_live), .return_from_irq_i(ret_pulse),
		.sleep_i(sleep), .q_phase_o(q_phase), .irq_take_o(irq_take), .vector_go_o(vector_go),
		.vector_addr_o(vec_addr), .restore_o(restore), .ctx_restore_o(ctx_restore), .wake_o(wake),
		.global_irq_enable_o(glb_en));
	ciu_core_model u_core (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ctx_set_i(ctx_set), .ctx_val_i(ctx_val),
		.ret_req_i(ret_req), .restore_i(restore), .ctx_restore_i(ctx_restore), .ctx_live_o(ctx_live),
		.return_from_irq_o(ret_pulse));

	initial begin
		ref_clk_i = 1'b0;
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end

	task automatic end_of_test;
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 4000) begin
			err_count++;
			end_of_test();
		end
	end

	task automatic chk(input logic [59:0] seen, input logic [59:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk_i);
		reg_wr <= 1'b0;
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
		@(posedge ref_clk_i);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk_i);
		reg_rd <= 1'b0;
		#1;
		rv = reg_rdata;
		chk(rv, e);
	endtask
	task automatic ev(input logic [4:0] e);
		@(posedge ref_clk_i);
		events <= e;
		@(posedge ref_clk_i);
		events <= '0;
	endtask
	task automatic pin(input logic v);
		@(posedge ref_clk_i);
		ext_pin <= v;
		repeat (5) @(posedge ref_clk_i);
	endtask
	task automatic setctx(input ciu_ctx_t v);
		@(posedge ref_clk_i);
		ctx_set <= 1'b1;
		ctx_val <= v;
		@(posedge ref_clk_i);
		ctx_set <= 1'b0;
	endtask
	// sel 0 entry pulse, 1 vector start, 2 restore pulse
	task automatic wait_for(input int sel, input int lim, output int c);
		c = 0;
		#1;
		while ((sel == 0 ? irq_take : sel == 1 ? vector_go : restore) !== 1'b1 && c < lim) begin
			@(posedge ref_clk_i);
			#1;
			c++;
		end
	endtask

	initial begin
		rst_i = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		ext_pin = 1'b0;
		pin_chg = 1'b0;
		sleep = 1'b0;
		ret_req = 1'b0;
		ctx_set = 1'b0;
		ctx_val = '0;
		events = '0;
		repeat (6) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		rdchk(CIU_A_CORE_CTRL, 8'h00);
		for (int i = 0; i < 4; i++) begin
			rdchk(CIU_A_EN_A + 12'(i), 8'h00);
			wr(CIU_A_EN_A + 12'(i), 8'hff);
			rdchk(CIU_A_EN_A + 12'(i), i[0] ? 8'h04 : 8'hc1);
			wr(CIU_A_EN_A + 12'(i), 8'h00);
		end
		rdchk(CIU_A_T0_OPT, 8'hff);
		rdchk(12'h0f0, 8'h00);
		// flags raised with every enable off
		ev(5'h1f);
		pin_chg <= 1'b1;
		rdchk(CIU_A_PEND_A, 8'hc1);
		rdchk(CIU_A_PEND_B, 8'h04);
		rdchk(CIU_A_CORE_CTRL, 8'h05);
		pin_chg <= 1'b0;
		wr(CIU_A_CORE_CTRL, 8'h01);
		rdchk(CIU_A_CORE_CTRL, 8'h00);
		// flags cleared before enabling
		wr(CIU_A_PEND_A, 8'h00);
		wr(CIU_A_PEND_B, 8'h00);
		setctx({8'hff, 8'h3c, 5'h1f, 7'h15, 16'h1234, 16'hbeef});
		wr(CIU_A_EN_A, 8'h40);
		wr(CIU_A_CORE_CTRL, 8'h80);
		ev(5'h02);
		wait_for(0, 20, n);
		chk(irq_take, 1'b0);
		wr(CIU_A_CORE_CTRL, 8'hc0);
		wait_for(0, 20, n);
		chk(irq_take, 1'b1);
		chk(q_phase, 2'h1);
		wait_for(1, 20, k);
		chk(k, 8);
		chk(vec_addr, 15'h0004);
		rdchk(CIU_A_CORE_CTRL, 8'h40);
		rdchk(12'hfe5, 8'h3c);
		rdchk(12'hfe4, 8'he7);
		wr(12'hfe5, 8'h5a);
		rdchk(12'hfe5, 8'h5a);
		wr(CIU_A_PEND_A, 8'h00);
		setctx({8'h00, 8'h11, 5'h00, 7'h00, 16'h0000, 16'h0000});
		@(posedge ref_clk_i);
		ret_req <= 1'b1;
		@(posedge ref_clk_i);
		ret_req <= 1'b0;
		wait_for(2, 10, k);
		chk(ctx_restore.w, 8'h5a);
		@(posedge ref_clk_i);
		#1;
		chk(ctx_live.w, 8'h5a);
		chk(glb_en, 1'b1);
		wr(CIU_A_CORE_CTRL, 8'h00);
		pin(1'b1);
		rdchk(CIU_A_CORE_CTRL, 8'h02);
		wr(CIU_A_CORE_CTRL, 8'h00);
		wr(CIU_A_T0_OPT, 8'hbf);
		pin(1'b0);
		rdchk(CIU_A_CORE_CTRL, 8'h02);
		wr(CIU_A_CORE_CTRL, 8'h00);
		pin(1'b1);
		rdchk(CIU_A_CORE_CTRL, 8'h00);
		wr(CIU_A_CORE_CTRL, 8'h90);
		@(posedge ref_clk_i);
		ext_pin <= 1'b0;
		wait_for(0, 30, n);
		chk(irq_take, 1'b1);
		wr(CIU_A_CORE_CTRL, 8'h00);
		// wake source enabled before sleep
		wr(CIU_A_CORE_CTRL, 8'ha0);
		@(posedge ref_clk_i);
		sleep <= 1'b1;
		ev(5'h10);
		#1;
		chk(wake, 1'b1);
		wait_for(0, 8, n);
		chk(irq_take, 1'b0);
		@(posedge ref_clk_i);
		sleep <= 1'b0;
		wait_for(0, 30, n);
		chk(irq_take, 1'b1);
		chk(n >= 4, 1'b1);
		// wake with global enable clear continues in line
		wr(CIU_A_CORE_CTRL, 8'h20);
		@(posedge ref_clk_i);
		sleep <= 1'b1;
		ev(5'h10);
		#1;
		chk(wake, 1'b1);
		@(posedge ref_clk_i);
		sleep <= 1'b0;
		wait_for(0, 20, n);
		chk(irq_take, 1'b0);
		end_of_test();
	end
endmodule
